// [logic/sram_sync_core.sv]
// Pipelined synchronous SRAM core: select, byte writes, output enable, sleep
`timescale 1ns/1ps
`include "sram_regs.svh"
//
// Function
// - Selected only when all three enables active
// - Global write or all lanes write everything
// - Outputs float after write until read
// - Outputs float after sleep until read
module sram_sync_core #(
    parameter int LANES      = `SRAM_LANES,
    parameter int LANE_W     = `SRAM_LANE_W,
    parameter int ADDR_W     = `SRAM_ADDR_W,
    parameter int FIFO_DEPTH = `SRAM_FIFO_DEPTH
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_chip_enable_primary_n,
    input  wire logic                    i_chip_enable_secondary_hi,
    input  wire logic                    i_chip_enable_third_n,
    input  wire logic                    i_processor_addr_strobe,
    input  wire logic                    i_controller_addr_strobe,
    input  wire logic                    i_global_write_n,
    input  wire logic                    i_byte_write_enable_n,
    input  wire logic [LANES-1:0]        i_byte_lane_write_n,
    input  wire logic [ADDR_W-1:0]       i_addr,
    input  wire logic [LANES*LANE_W-1:0] i_dq_in,
    input  wire logic                    i_sleep_request,
    output logic      [LANES*LANE_W-1:0] o_dq_out,
    output logic                         o_dq_oe,
    output logic                         o_wr_ready,
    output logic                         o_sleeping
);
    import sram_pkg::*;

    localparam int DW   = LANES * LANE_W;
    localparam int PINW = 8 + LANES + ADDR_W + DW;
    localparam int FW   = ADDR_W + LANES + DW;

    initial begin
        if (LANES < 1 || LANE_W < 1 || ADDR_W < 1 || ADDR_W > 20) begin
            $error("sram_sync_core: unsupported geometry");
        end
        if (FIFO_DEPTH < 2) begin
            $error("sram_sync_core: write queue needs two entries");
        end
    end

    // Every pin crosses two flops before any decode reads it
    // Only the second stage is read, so a metastable first stage never fans out
    logic [PINW-1:0] pin_meta_q, pin_sync_q;
    always_ff @(posedge i_clk) begin
        pin_meta_q <= {i_chip_enable_primary_n, i_chip_enable_secondary_hi,
                       i_chip_enable_third_n, i_processor_addr_strobe,
                       i_controller_addr_strobe, i_global_write_n,
                       i_byte_write_enable_n, i_sleep_request,
                       i_byte_lane_write_n, i_addr, i_dq_in};
        pin_sync_q <= pin_meta_q;
    end

    // Decoded copies of the synchronised pins
    logic              sel_primary_n;
    logic              sel_secondary;
    logic              sel_third_n;
    logic              proc_strobe_n;
    logic              ctrl_strobe_n;
    logic              all_write_n;
    logic              lane_write_en_n;
    logic              sleep_in;
    logic [LANES-1:0]  lane_n;
    logic [ADDR_W-1:0] addr;
    logic [DW-1:0]     din;
    assign {sel_primary_n, sel_secondary, sel_third_n, proc_strobe_n, ctrl_strobe_n,
            all_write_n, lane_write_en_n, sleep_in, lane_n, addr, din} = pin_sync_q;

    logic             selected, strobe, launch_read, launch_write;
    logic [LANES-1:0] lane_mask;

    always_comb begin
        selected = !sel_primary_n && sel_secondary && !sel_third_n;
        strobe   = !proc_strobe_n || !ctrl_strobe_n;
        if (!all_write_n) begin
            lane_mask = '1;
        end else if (!lane_write_en_n) begin
            lane_mask = ~lane_n;
        end else begin
            lane_mask = '0;
        end
        // A selected processor strobe always starts a read, as on the real bus
        launch_write = strobe && selected && proc_strobe_n && (lane_mask != '0);
        launch_read  = strobe && selected && !launch_write;
    end

    sram_state_type state_q, state_d;
    logic           oe_q, oe_d, rd_pend_q, rd_pend_d;

    always_comb begin
        state_d   = state_q;
        oe_d      = oe_q;
        rd_pend_d = 1'b0;
        unique case (state_q)
            st_active: begin
                // Sleep is entered only while deselected; a selected request waits
                if (sleep_in && !selected) begin
                    state_d = st_sleep;
                    oe_d    = 1'b0;
                end else begin
                    if (launch_read) begin
                        rd_pend_d = 1'b1;
                    end
                    // A float decoded now beats a read answer due now, so a
                    // write right behind a read never leaves the bus driven
                    if (launch_write || (strobe && !selected)) begin
                        oe_d = 1'b0;
                    end else if (rd_pend_q) begin
                        oe_d = 1'b1;
                    end
                end
            end
            // Strobes in sleep are ignored; only the sleep pin is watched
            st_sleep: begin
                oe_d = 1'b0;
                if (!sleep_in) begin
                    state_d = st_active;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q   <= st_active;
            oe_q      <= `SRAM_OE_RST;
            rd_pend_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            oe_q      <= oe_d;
            rd_pend_q <= rd_pend_d;
        end
    end

    // Writes queue here so the array port stays free for reads
    logic          wq_in_ready, wq_out_valid, wq_out_ready;
    logic [FW-1:0] wq_out_data;
    logic          wr_accept;

    assign wr_accept    = (state_q == st_active) && launch_write && !sleep_in;
    // Draining pauses on a read launch so the array sees one access a cycle
    assign wq_out_ready = (state_q == st_active) && !launch_read;

    sram_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_write_queue (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (wr_accept),
        .o_in_ready  (wq_in_ready),
        .i_in_data   ({addr, lane_mask, din}),
        .o_out_valid (wq_out_valid),
        .i_out_ready (wq_out_ready),
        .o_out_data  (wq_out_data)
    );

    logic [ADDR_W-1:0] wq_addr;
    logic [LANES-1:0]  wq_mask;
    logic [DW-1:0]     wq_data;
    assign {wq_addr, wq_mask, wq_data} = wq_out_data;

    // Limitation: a read does not see writes still waiting in the queue
    // Lanes merge into one word so a single process owns the array
    logic [DW-1:0] array_q [1 << ADDR_W];
    logic [DW-1:0] merge_word;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign merge_word[g*LANE_W +: LANE_W] = wq_mask[g]
                ? wq_data[g*LANE_W +: LANE_W] : array_q[wq_addr][g*LANE_W +: LANE_W];
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (wq_out_valid && wq_out_ready) begin
            array_q[wq_addr] <= merge_word;
        end
    end

    logic [DW-1:0] rd_q, rd_d, dq_q, dq_d;
    always_comb begin
        rd_d = launch_read ? array_q[addr] : rd_q;
        dq_d = rd_pend_q ? rd_q : dq_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_q <= '0;
            dq_q <= {DW{`SRAM_DQ_RST}};
        end else begin
            rd_q <= rd_d;
            dq_q <= dq_d;
        end
    end

    logic wr_ready_q, sleeping_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ready_q <= 1'b0;
            sleeping_q <= 1'b0;
        end else begin
            wr_ready_q <= wq_in_ready;
            sleeping_q <= (state_d == st_sleep);
        end
    end

    // Outputs leave straight from flops so the pins never see decode glitches
    assign o_dq_out   = dq_q;
    assign o_dq_oe    = oe_q;
    assign o_wr_ready = wr_ready_q;
    assign o_sleeping = sleeping_q;
endmodule // sram_sync_core

// [shared/sram_regs.svh]
// Constants for the synchronous SRAM select, write and sleep block
`ifndef SRAM_REGS_SVH
`define SRAM_REGS_SVH
`define SRAM_LANES       4
`define SRAM_LANE_W      9
`define SRAM_ADDR_W      4
`define SRAM_FIFO_DEPTH  16
`define SRAM_SYNC_STAGES 2
`define SRAM_OE_RST      1'b0
`define SRAM_DQ_RST      1'b0
`endif

// [shared/sram_pkg.sv]
// Types shared by the SRAM block
package sram_pkg;
    typedef enum logic [0:0] {
        st_active,
        st_sleep
    } sram_state_type;
endpackage

// [logic/sram_fifo.sv]
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sram_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
            $error("sram_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]      cnt_q, cnt_d;
    logic             push, pop;

    always_comb begin
        push = i_in_valid && (cnt_q != (PW+1)'(DEPTH));
        pop  = i_out_ready && (cnt_q != '0);
        wr_d = push ? wr_q + PW'(1) : wr_q;
        rd_d = pop ? rd_q + PW'(1) : rd_q;
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; the count guards every read
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    assign o_in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];
endmodule // sram_fifo

// [verif/sram_sync_core_props.sv]
// Checks on select, float and sleep timing of the SRAM core
`timescale 1ns/1ps
module sram_sync_core_props #(
    parameter int LANES = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_chip_enable_primary_n,
    input wire logic i_chip_enable_secondary_hi,
    input wire logic i_chip_enable_third_n,
    input wire logic i_processor_addr_strobe,
    input wire logic i_controller_addr_strobe,
    input wire logic i_global_write_n,
    input wire logic i_byte_write_enable_n,
    input wire logic [LANES-1:0] i_byte_lane_write_n,
    input wire logic i_sleep_request,
    input wire logic o_dq_oe,
    input wire logic o_sleeping
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic sel, stb, wr, rd;
    assign sel = !i_chip_enable_primary_n && i_chip_enable_secondary_hi && !i_chip_enable_third_n;
    assign stb = !i_processor_addr_strobe || !i_controller_addr_strobe;
    assign wr = i_processor_addr_strobe && !i_controller_addr_strobe
        && (!i_global_write_n || (!i_byte_write_enable_n && !(&i_byte_lane_write_n)));
    assign rd = sel && stb && !wr;
    read_drive_a: assert property (rd && !o_sleeping && !i_sleep_request ##1
        (!stb && !i_sleep_request) [*3] |=> o_dq_oe) else $error("read did not drive bus");
    write_float_a: assert property (sel && wr && !o_sleeping |-> ##3 !o_dq_oe)
        else $error("bus driven after write");
    oe_cause_a: assert property ($rose(o_dq_oe) |-> $past(rd, 4))
        else $error("bus driven without read");
    desel_float_a: assert property (!sel && stb && !o_sleeping |-> ##3 !o_dq_oe)
        else $error("bus driven while deselected");
    sleep_entry_a: assert property (!sel && i_sleep_request ##1
        (!sel && i_sleep_request) [*2] |=> o_sleeping) else $error("sleep not entered");
    sleep_float_a: assert property (o_sleeping |-> !o_dq_oe)
        else $error("bus driven in sleep");
    wake_exit_a: assert property ($fell(i_sleep_request) ##1 !i_sleep_request [*2]
        |=> !o_sleeping) else $error("sleep not left");
    wake_float_a: assert property ($fell(o_sleeping) |-> !o_dq_oe)
        else $error("bus driven on wake");
endmodule // sram_sync_core_props
bind sram_sync_core sram_sync_core_props #(.LANES(LANES)) sram_sync_core_props_i (.i_clk,
    .i_rst, .i_chip_enable_primary_n, .i_chip_enable_secondary_hi, .i_chip_enable_third_n,
    .i_processor_addr_strobe, .i_controller_addr_strobe, .i_global_write_n,
    .i_byte_write_enable_n, .i_byte_lane_write_n, .i_sleep_request, .o_dq_oe, .o_sleeping);

// [verif/sram_host_model.sv]
// Controller model turning bench operations into SRAM bus pins
`timescale 1ns/1ps
module sram_host_model (
    input  wire logic [1:0]  i_op,
    input  wire logic [1:0]  i_desel,
    input  wire logic        i_use_gw,
    input  wire logic [3:0]  i_lanes_n,
    input  wire logic [35:0] i_data,
    output logic      [7:0]  o_ctl,
    output logic      [3:0]  o_byte_lane_write_n,
    output logic      [35:0] o_dq
);
    logic       act;
    logic       pread;
    logic [1:0] d;
    assign act = i_op == 2'h1 || i_op == 2'h2;
    // Reads with the global write flag clear go out on the processor strobe
    assign pread = i_op == 2'h1 && !i_use_gw;
    // Idle and sleep always pick a deselect, so sleep never meets a selected device
    assign d = (act || i_desel != 2'h0) ? i_desel : 2'h1;
    assign o_ctl = {i_op == 2'h3, !(i_op == 2'h2 && !i_use_gw), !(i_op == 2'h2 && i_use_gw),
        !(act && !pread), !pread, d == 2'h3, d != 2'h2, d == 2'h1};
    assign o_byte_lane_write_n = i_op == 2'h2 ? i_lanes_n : 4'hF;
    // Released bus shows the inverse so a stale value cannot pass for written data
    assign o_dq = i_op == 2'h2 ? i_data : ~i_data;
endmodule // sram_host_model

// [verif/sram_sync_core_tb_top.sv]
// Random bench for select, byte writes and sleep of the SRAM core
`timescale 1ns/1ps
module sram_sync_core_tb_top;
    logic i_clk = 1'b0, i_rst = 1'b1, use_gw = 1'b1;
    logic [1:0] op = 2'h0, desel = 2'h0;
    logic [3:0] lanes = 4'hF, addr = 4'h0;
    logic [35:0] data = 36'h0, mem [16];
    logic [7:0] ctl;
    logic [3:0] lanes_n;
    logic [35:0] dq, dq_out;
    logic oe, sleeping, wr_ready;
    int fail_count = 0, n_compared = 0;
    initial forever #4 i_clk = ~i_clk;
    sram_host_model sram_host_model_i (.i_op(op), .i_desel(desel), .i_use_gw(use_gw),
        .i_lanes_n(lanes), .i_data(data), .o_ctl(ctl), .o_byte_lane_write_n(lanes_n), .o_dq(dq));
    sram_sync_core sram_sync_core_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_chip_enable_primary_n(ctl[0]), .i_chip_enable_secondary_hi(ctl[1]),
        .i_chip_enable_third_n(ctl[2]), .i_processor_addr_strobe(ctl[3]),
        .i_controller_addr_strobe(ctl[4]), .i_global_write_n(ctl[5]),
        .i_byte_write_enable_n(ctl[6]), .i_byte_lane_write_n(lanes_n), .i_addr(addr),
        .i_dq_in(dq), .i_sleep_request(ctl[7]), .o_dq_out(dq_out), .o_dq_oe(oe),
        .o_wr_ready(wr_ready), .o_sleeping(sleeping));
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic drive(input logic [1:0] o, input logic [3:0] a, input logic [1:0] d);
        @(posedge i_clk);
        #1 op = o;
        addr = a;
        desel = d;
    endtask
    task automatic idle(input int n);
        repeat (n) drive(2'h0, addr, 2'h0);
    endtask
    task automatic rd(input logic [3:0] a, input logic [1:0] d, input logic exp_oe);
        use_gw = 1'($urandom());
        drive(2'h1, a, d);
        idle(5);
        chk("output enable", 36'(exp_oe), 36'(oe));
        if (exp_oe) chk("read data", mem[a], dq_out);
    endtask
    task automatic wr(input logic [3:0] a, input logic g, input logic [3:0] m);
        @(posedge i_clk);
        #1 data = 36'({$urandom(), $urandom()});
        use_gw = g;
        lanes = m;
        drive_now: op = 2'h2;
        addr = a;
        desel = 2'h0;
        for (int k = 0; k < 4; k++) if (g || !m[k]) mem[a][k*9+:9] = data[k*9+:9];
    endtask
    initial begin
        void'($urandom(32'h42C425FA));
        repeat (6) @(posedge i_clk);
        #1 i_rst = 1'b0;
        chk("output enable in reset", 36'h0, 36'(oe));
        chk("read data in reset", 36'h0, dq_out);
        chk("sleeping in reset", 36'h0, 36'(sleeping));
        chk("write ready in reset", 36'h0, 36'(wr_ready));
        for (int a = 0; a < 16; a++) wr(4'(a), 1'b1, 4'hF);
        idle(20);
        chk("write ready", 36'h1, 36'(wr_ready));
        for (int a = 0; a < 16; a++) rd(4'(a), 2'h0, 1'b1);
        wr(4'h3, 1'b0, 4'h0);
        wr(4'h5, 1'b0, 4'hE);
        repeat (30) wr(4'($urandom()), 1'($urandom()), 4'($urandom()));
        idle(20);
        for (int a = 0; a < 16; a++) rd(4'(a), 2'h0, 1'b1);
        wr(4'h0, 1'b1, 4'hF);
        idle(8);
        chk("output enable after write", 36'h0, 36'(oe));
        for (int d = 1; d < 4; d++) begin
            rd(4'h1, 2'h0, 1'b1);
            rd(4'h1, 2'(d), 1'b0);
            rd(4'h2, 2'h0, 1'b1);
            repeat (5) drive(2'h3, addr, 2'(d));
            chk("sleeping", 36'h1, 36'(sleeping));
            chk("output enable in sleep", 36'h0, 36'(oe));
            idle(5);
            chk("awake", 36'h0, 36'(sleeping));
            chk("output enable on wake", 36'h0, 36'(oe));
            rd(4'h2, 2'h0, 1'b1);
        end
        give_verdict();
    end
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
endmodule // sram_sync_core_tb_top
